// >>> src/fcs_pkg.sv
// Package of constants and types for the clock system block.
// How it works
// - Loop measures oscillator over two reference periods.
// - Enabled loop compares at once, two-plus-one periods.
// - Sleep modes can gate loop; interrupts re-enable it, except in sleep one.
// - Modulation mixes selected tap and next tap.
// - Modulation rolls over at 31, no upward jump.
// - Source-select writes switch each clock's source.
// - Crystal faults set flags; enabled fault raises interrupt.
// - Idle asynchronous serial clock stops in deep sleep.
// - Bypass clear leaves bypass; deepest sleep lowers current unless bypassed.
// - Sleep zero keeps loop running while oscillator used.
// - Sleep one keeps loop off during interrupt service while oscillator unused.
package fcs_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_CLOCK_SELECT = 4'h0;
  localparam logic [3:0] ADDR_CRYSTAL_CTRL = 4'h1;
  localparam logic [3:0] ADDR_FAULT_STATUS = 4'h2;
  localparam logic [3:0] ADDR_LOOP_CTRL = 4'h3;
  localparam logic [3:0] ADDR_LOOP_STATE = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_LOOP_TARGET = 4'h7;
  // Clock select field positions: aux [2:0], subsystem [6:4], main [10:8].
  localparam int SEL_AUX_LSB = 0;
  localparam int SEL_SUB_LSB = 4;
  localparam int SEL_MAIN_LSB = 8;
  localparam logic [15:0] CLOCK_SELECT_RESET = 16'h0344;
  // Crystal control bits.
  localparam int XC_BYPASS_BIT = 0;
  localparam int XC_NMI_EN_BIT = 1;
  localparam logic [15:0] CRYSTAL_CTRL_RESET = 16'h0000;
  // Fault status bits: crystal one, crystal two, oscillator, aggregate.
  localparam int FS_XT1_BIT = 0;
  localparam int FS_XT2_BIT = 1;
  localparam int FS_OSC_BIT = 2;
  localparam int FS_AGG_BIT = 3;
  // Loop control bits and the default measured target.
  localparam int LC_ENABLE_BIT = 0;
  localparam logic [15:0] LOOP_CTRL_RESET = 16'h0001;
  localparam logic [15:0] LOOP_TARGET_RESET = 16'h0100;
  // Interrupt status bits.
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_STEP_BIT = 1;
  localparam int IRQ_SETTLED_BIT = 2;
  // ****************************************************************
  // Loop timing and oscillator sources
  // ****************************************************************
  localparam int CAPTURE_REF_PERIODS = 2;
  localparam int ADJUST_REF_PERIODS = 1;
  localparam int SETTLE_REF_PERIODS = 32 * 32;
  localparam logic [4:0] MOD_TOP = 5'h1F;
  localparam logic [2:0] SRC_CRYSTAL_ONE = 3'h0;
  localparam logic [2:0] SRC_OSC = 3'h3;
  localparam logic [2:0] SRC_OSC_DIV = 3'h4;
  localparam logic [2:0] SRC_CRYSTAL_TWO = 3'h5;

  typedef enum logic [2:0]
  {
    PWR_ACTIVE,
    PWR_SLEEP_ZERO,
    PWR_SLEEP_ONE,
    PWR_SLEEP_TWO,
    PWR_SLEEP_THREE,
    PWR_SLEEP_FOUR
  } fcs_power_t;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } fcs_bus_req_t;

  typedef struct packed
  {
    logic [2:0] main_sel;
    logic [2:0] sub_sel;
    logic [2:0] aux_sel;
  } fcs_clk_sel_t;

  typedef struct packed
  {
    logic [4:0] tap;
    logic [4:0] mod;
  } fcs_osc_set_t;
endpackage : fcs_pkg

// >>> src/fcs_sync3.sv
// Three-stage input synchroniser with agreement detect.
`timescale 1ns/1ns
`default_nettype none
module fcs_sync3
#(
  parameter int WIDTH = 1
)
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire logic [WIDTH-1:0] I_ASYNC,
  output logic [WIDTH-1:0] O_SYNC
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] held_r;
  logic [WIDTH-1:0] agree;

  // A change counts only once the second and third stages agree.
  assign agree = ~(s2_r ^ s3_r);
  assign O_SYNC = held_r;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      // The stages keep sampling through reset, so that they hold the pin's
      // real level at release and no false change follows it.
      s1_r <= I_ASYNC;
      s2_r <= s1_r;
      s3_r <= s2_r;
      held_r <= s3_r;
    end
    else if (I_CE)
    begin
      s1_r <= I_ASYNC;
      s2_r <= s1_r;
      s3_r <= s2_r;
      held_r <= (agree & s3_r) | (~agree & held_r);
    end
  end
endmodule : fcs_sync3
`default_nettype wire

// >>> src/fcs_clock_system.sv
// Clock system: frequency lock loop, source selects, faults, sleep gating.
`timescale 1ns/1ns
`default_nettype none
module fcs_clock_system
#(
  parameter int REF_DIV = 610,
  parameter int SETTLE_PERIODS = fcs_pkg::SETTLE_REF_PERIODS
)
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire fcs_pkg::fcs_bus_req_t I_BUS,
  output logic [15:0] O_RDATA,
  input wire logic I_REF_CLK,
  input wire logic I_OSC_TICK,
  input wire logic I_CRYSTAL_ONE_OK,
  input wire logic I_CRYSTAL_TWO_OK,
  input wire logic I_OSC_OK,
  input wire fcs_pkg::fcs_power_t I_POWER_MODE,
  input wire logic I_CLOCK_GATE_BIT_TWO,
  input wire logic I_IRQ_ACTIVE,
  input wire logic I_SERIAL_OUT_OF_RESET,
  input wire logic I_SERIAL_ASYNC_MODE,
  input wire logic I_SERIAL_BUSY,
  output fcs_pkg::fcs_clk_sel_t O_CLK_SEL,
  output fcs_pkg::fcs_osc_set_t O_OSC_SET,
  output logic O_OSC_USE_NEXT_TAP,
  output logic O_LOOP_RUNNING,
  output logic O_OSC_ENABLE,
  output logic O_SERIAL_CLK_EN,
  output logic O_CRYSTAL_ONE_BYPASS,
  output logic O_LOW_CURRENT_OK,
  output logic O_OSC_FAULT_NMI,
  output logic O_IRQ
);
  import fcs_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [1:0]
  {
    LOOP_IDLE,
    LOOP_CAPTURE,
    LOOP_ADJUST
  } fcs_loop_state_t;

  fcs_loop_state_t loop_state_r;
  fcs_loop_state_t loop_state_nxt;
  logic [15:0] clock_select_r;
  logic [15:0] crystal_ctrl_r;
  logic [15:0] loop_ctrl_r;
  logic [15:0] loop_target_r;
  logic [2:0] fault_r;
  logic [2:0] irq_status_r;
  logic [2:0] irq_mask_r;
  logic [15:0] osc_count_r;
  logic [15:0] measured_r;
  logic [1:0] ref_edges_r;
  logic [4:0] tap_r;
  logic [4:0] mod_r;
  logic [4:0] mod_phase_r;
  logic [10:0] settle_cnt_r;
  logic ref_prev_r;
  logic ref_sync;
  logic osc_tick_sync;
  logic [2:0] ok_sync;
  logic ref_rise;
  logic loop_enable;
  logic osc_feeds_periph;
  logic loop_gated;
  logic wr_clock_select;
  logic wr_crystal_ctrl;
  logic wr_fault;
  logic wr_irq_status;
  logic wr_loop_ctrl;
  logic wr_loop_target;
  logic wr_irq_mask;
  logic [2:0] fault_set;
  logic [2:0] irq_set;
  logic [15:0] rdata_nxt;
  logic step_done;
  fcs_osc_set_t step_next;

  function automatic logic sel_is_osc(input logic [2:0] sel);
    sel_is_osc = (sel == SRC_OSC) || (sel == SRC_OSC_DIV);
  endfunction : sel_is_osc

  // Step the tap/modulation pair as one number, so that rolling over the
  // modulation count carries into the tap and never produces a high jump.
  function automatic fcs_osc_set_t osc_step(input fcs_osc_set_t cur,
                                            input logic up);
    logic [9:0] joint;
    joint = {cur.tap, cur.mod};
    if (up && joint != 10'h3FF)
      joint = joint + 10'h001;
    else if (!up && joint != 10'h000)
      joint = joint - 10'h001;
    osc_step = fcs_osc_set_t'(joint);
  endfunction : osc_step

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // The reference clock shares the status pins' synchroniser, so that its
  // edges and the fault flags see the same latency.
  fcs_sync3 #(.WIDTH(5)) u_sync
  (
    .I_SYS_CLK(I_SYS_CLK),
    .I_RST_B(I_RST_B),
    .I_CE(I_CE),
    .I_ASYNC({I_REF_CLK, I_OSC_TICK, I_OSC_OK, I_CRYSTAL_TWO_OK,
              I_CRYSTAL_ONE_OK}),
    .O_SYNC({ref_sync, osc_tick_sync, ok_sync})
  );

  // ****************************************************************
  // Decoding and gating
  // ****************************************************************
  assign wr_clock_select = I_BUS.wr && I_BUS.addr == ADDR_CLOCK_SELECT;
  assign wr_crystal_ctrl = I_BUS.wr && I_BUS.addr == ADDR_CRYSTAL_CTRL;
  assign wr_fault = I_BUS.wr && I_BUS.addr == ADDR_FAULT_STATUS;
  assign wr_irq_status = I_BUS.wr && I_BUS.addr == ADDR_IRQ_STATUS;
  assign wr_loop_ctrl = I_BUS.wr && I_BUS.addr == ADDR_LOOP_CTRL;
  assign wr_loop_target = I_BUS.wr && I_BUS.addr == ADDR_LOOP_TARGET;
  assign wr_irq_mask = I_BUS.wr && I_BUS.addr == ADDR_IRQ_MASK;
  assign ref_rise = ref_sync && !ref_prev_r;

  assign O_CLK_SEL.main_sel = clock_select_r[SEL_MAIN_LSB +: 3];
  assign O_CLK_SEL.sub_sel = clock_select_r[SEL_SUB_LSB +: 3];
  assign O_CLK_SEL.aux_sel = clock_select_r[SEL_AUX_LSB +: 3];

  assign osc_feeds_periph = sel_is_osc(O_CLK_SEL.sub_sel) ||
                            sel_is_osc(O_CLK_SEL.aux_sel);
  // Sleep zero gates the loop only when the oscillator feeds no peripheral
  // clock, and an interrupt brings it back; sleep one keeps it off even
  // during service, and deeper modes gate it on the clock-gate bit.
  assign loop_gated =
    (I_POWER_MODE == PWR_SLEEP_ZERO && !osc_feeds_periph && !I_IRQ_ACTIVE) ||
    (I_POWER_MODE == PWR_SLEEP_ONE && !osc_feeds_periph) ||
    (I_POWER_MODE >= PWR_SLEEP_TWO && I_CLOCK_GATE_BIT_TWO &&
     !I_IRQ_ACTIVE);
  assign loop_enable = loop_ctrl_r[LC_ENABLE_BIT] && !loop_gated;
  assign O_LOOP_RUNNING = loop_enable;
  // The oscillator may only stop once neither the loop nor any clock
  // consumer needs it; the main clock counts only while the core is awake.
  assign O_OSC_ENABLE = loop_enable || osc_feeds_periph ||
                        sel_is_osc(O_CLK_SEL.main_sel) &&
                        I_POWER_MODE == PWR_ACTIVE;

  // An idle asynchronous serial port drops its clock in the deep modes.
  assign O_SERIAL_CLK_EN = !(I_POWER_MODE >= PWR_SLEEP_THREE &&
                             I_SERIAL_OUT_OF_RESET &&
                             I_SERIAL_ASYNC_MODE &&
                             !I_SERIAL_BUSY);

  assign O_CRYSTAL_ONE_BYPASS = crystal_ctrl_r[XC_BYPASS_BIT];
  assign O_LOW_CURRENT_OK = I_POWER_MODE == PWR_SLEEP_FOUR &&
                            !crystal_ctrl_r[XC_BYPASS_BIT];

  assign fault_set = ~ok_sync;
  assign O_OSC_FAULT_NMI = (|fault_r) &&
                           crystal_ctrl_r[XC_NMI_EN_BIT];

  assign O_OSC_SET.tap = tap_r;
  assign O_OSC_SET.mod = mod_r;
  // Modulation pattern: out of 32 slots, mod count slots use the next tap.
  assign O_OSC_USE_NEXT_TAP = mod_phase_r < mod_r;

  assign step_done = loop_state_r == LOOP_ADJUST && ref_rise;
  assign step_next = osc_step(O_OSC_SET,
                              measured_r < loop_target_r);
  // The fault event is a level, so a clear while a fault persists is
  // undone at once; software must mend the source before clearing.
  assign irq_set = {settle_cnt_r == 11'(SETTLE_PERIODS) && step_done,
                    step_done, |fault_r};
  assign O_IRQ = |(irq_status_r & irq_mask_r);

  // Unmapped offsets read as zero, so software can probe the map safely.
  // Reads have no side effects: flags clear only by writing ones.
  always_comb
  begin
    case (I_BUS.addr)
      ADDR_CLOCK_SELECT: rdata_nxt = clock_select_r;
      ADDR_CRYSTAL_CTRL: rdata_nxt = crystal_ctrl_r;
      ADDR_FAULT_STATUS: rdata_nxt = {12'h000, |fault_r, fault_r};
      ADDR_LOOP_CTRL: rdata_nxt = loop_ctrl_r;
      ADDR_LOOP_STATE: rdata_nxt = {6'h00, tap_r, mod_r};
      ADDR_IRQ_STATUS: rdata_nxt = {13'h0000, irq_status_r};
      ADDR_IRQ_MASK: rdata_nxt = {13'h0000, irq_mask_r};
      ADDR_LOOP_TARGET: rdata_nxt = loop_target_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // ****************************************************************
  // Loop sequencer
  // ****************************************************************
  always_comb
  begin
    loop_state_nxt = loop_state_r;
    case (loop_state_r)
      // Comparing starts at once: the next reference rise opens capture.
      LOOP_IDLE: if (loop_enable && ref_rise) loop_state_nxt = LOOP_CAPTURE;
      LOOP_CAPTURE:
        if (ref_rise && ref_edges_r == 2'(CAPTURE_REF_PERIODS - 1))
          loop_state_nxt = LOOP_ADJUST;
      LOOP_ADJUST: if (ref_rise) loop_state_nxt = LOOP_CAPTURE;
      default: loop_state_nxt = LOOP_IDLE;
    endcase
    if (!loop_enable)
      loop_state_nxt = LOOP_IDLE;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      clock_select_r <= CLOCK_SELECT_RESET;
      crystal_ctrl_r <= CRYSTAL_CTRL_RESET;
      loop_ctrl_r <= LOOP_CTRL_RESET;
      loop_target_r <= LOOP_TARGET_RESET;
      irq_mask_r <= 3'h0;
      O_RDATA <= 16'h0000;
    end
    else if (I_CE)
    begin
      if (wr_clock_select)
        clock_select_r <= {5'h00, I_BUS.wdata[10:8], 1'b0,
                           I_BUS.wdata[6:4], 1'b0, I_BUS.wdata[2:0]};
      if (wr_crystal_ctrl)
        crystal_ctrl_r <= {14'h0000, I_BUS.wdata[1:0]};
      if (wr_loop_ctrl)
        loop_ctrl_r <= {15'h0000, I_BUS.wdata[LC_ENABLE_BIT]};
      if (wr_loop_target)
        loop_target_r <= I_BUS.wdata;
      if (wr_irq_mask)
        irq_mask_r <= I_BUS.wdata[2:0];
      // Zero outside the read slot lets several slaves share one bus.
      O_RDATA <= I_BUS.rd ? rdata_nxt : 16'h0000;
    end
  end

  // Flags: a hardware set in the clearing cycle wins over the clear.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      fault_r <= 3'h0;
      irq_status_r <= 3'h0;
    end
    else if (I_CE)
    begin
      fault_r <= (fault_r & ~(wr_fault ? I_BUS.wdata[2:0] : 3'h0)) |
                 fault_set;
      irq_status_r <= (irq_status_r &
                       ~(wr_irq_status ? I_BUS.wdata[2:0] : 3'h0)) |
                      irq_set;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      loop_state_r <= LOOP_IDLE;
      // Track the synchronised level through reset, so that a reference
      // clock that is high at release is not taken for a rising edge.
      ref_prev_r <= ref_sync;
      ref_edges_r <= 2'h0;
      osc_count_r <= 16'h0000;
      measured_r <= 16'h0000;
    end
    else if (I_CE)
    begin
      loop_state_r <= loop_state_nxt;
      ref_prev_r <= ref_sync;
      if (loop_state_r != LOOP_CAPTURE)
      begin
        ref_edges_r <= 2'h0;
        osc_count_r <= 16'h0000;
      end
      else
      begin
        if (osc_tick_sync)
          osc_count_r <= osc_count_r + 16'h0001;
        if (ref_rise)
          ref_edges_r <= ref_edges_r + 2'h1;
        if (loop_state_nxt == LOOP_ADJUST)
          measured_r <= osc_count_r;
      end
    end
  end

  // ****************************************************************
  // Tap and modulation
  // ****************************************************************
  // Only the rise that ends an adjust period moves the pair, so a loop that
  // is gated early never applies a half-finished measurement.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      tap_r <= 5'h10;
      mod_r <= 5'h00;
    end
    else if (I_CE && step_done)
    begin
      tap_r <= step_next.tap;
      mod_r <= step_next.mod;
    end
  end

  // The phase runs on oscillator activity whether or not the loop runs, so
  // the mix of taps holds while the loop is gated.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
      mod_phase_r <= 5'h00;
    else if (I_CE && osc_tick_sync)
      mod_phase_r <= mod_phase_r + 5'h01;
  end

  // ****************************************************************
  // Settling count
  // ****************************************************************
  // Steps are counted rather than reference periods; the count is capped so
  // that the settled interrupt keeps firing on every later step.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
      settle_cnt_r <= 11'h000;
    else if (I_CE)
    begin
      if (!loop_enable)
        settle_cnt_r <= 11'h000;
      else if (step_done && settle_cnt_r != 11'(SETTLE_PERIODS))
        settle_cnt_r <= settle_cnt_r + 11'h001;
    end
  end
endmodule : fcs_clock_system
`default_nettype wire

// >>> sim/fcs_partner.sv
// Far-side model: reference clock, oscillator activity and crystals.
`timescale 1ns/1ns
`default_nettype none
module fcs_partner
#(
  parameter int REF_HALF_NS = 400
)
(
  input wire logic i_xt1_fit,
  input wire logic i_xt2_fit,
  output logic o_ref_clk,
  output logic o_osc_tick,
  output logic o_xt1_ok,
  output logic o_xt2_ok,
  output logic o_osc_ok
);
  // ****************************************************************
  // Sources
  // ****************************************************************
  // The offset keeps reference edges away from system clock edges.
  initial
  begin
    o_ref_clk = 1'b0;
    #13;
    forever #(REF_HALF_NS) o_ref_clk = ~o_ref_clk;
  end
  assign o_osc_tick = 1'b1;
  assign o_xt1_ok = i_xt1_fit;
  assign o_xt2_ok = i_xt2_fit;
  assign o_osc_ok = 1'b1;
endmodule : fcs_partner
`default_nettype wire

// >>> sim/fcs_clock_system_asserts.sv
// Port checker for the clock system.
`timescale 1ns/1ns
`default_nettype none
module fcs_clock_system_asserts
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire fcs_pkg::fcs_bus_req_t I_BUS,
  input wire logic [15:0] O_RDATA,
  input wire fcs_pkg::fcs_power_t I_POWER_MODE,
  input wire logic I_CLOCK_GATE_BIT_TWO,
  input wire logic I_IRQ_ACTIVE,
  input wire logic I_SERIAL_OUT_OF_RESET,
  input wire logic I_SERIAL_ASYNC_MODE,
  input wire logic I_SERIAL_BUSY,
  input wire fcs_pkg::fcs_clk_sel_t O_CLK_SEL,
  input wire fcs_pkg::fcs_osc_set_t O_OSC_SET,
  input wire logic O_LOOP_RUNNING,
  input wire logic O_OSC_ENABLE,
  input wire logic O_SERIAL_CLK_EN,
  input wire logic O_CRYSTAL_ONE_BYPASS,
  input wire logic O_LOW_CURRENT_OK
);
  import fcs_pkg::*;
  // ****************************************************************
  // Properties
  // ****************************************************************
  wire osc_side = O_CLK_SEL.sub_sel inside {SRC_OSC, SRC_OSC_DIV}
    || O_CLK_SEL.aux_sel inside {SRC_OSC, SRC_OSC_DIV};
  wire serial_idle = I_POWER_MODE >= PWR_SLEEP_THREE && I_SERIAL_OUT_OF_RESET
    && I_SERIAL_ASYNC_MODE && !I_SERIAL_BUSY;
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_B);
  read_idle_a: assert property (!$past(I_BUS.rd) |-> O_RDATA == 16'h0000)
    else $error("read data outside read slot");
  clk_sel_a: assert property (I_CE && I_BUS.wr && I_BUS.addr ==
    ADDR_CLOCK_SELECT |=> O_CLK_SEL == {$past(I_BUS.wdata[10:8]),
    $past(I_BUS.wdata[6:4]), $past(I_BUS.wdata[2:0])})
    else $error("clock select not applied");
  osc_step_a: assert property (O_OSC_SET != $past(O_OSC_SET) |->
    O_OSC_SET == $past(O_OSC_SET) + 10'h001
    || O_OSC_SET == $past(O_OSC_SET) - 10'h001)
    else $error("tap and modulation jumped");
  deep_gate_a: assert property (I_POWER_MODE >= PWR_SLEEP_TWO &&
    I_CLOCK_GATE_BIT_TWO && !I_IRQ_ACTIVE |-> !O_LOOP_RUNNING)
    else $error("loop runs in gated deep sleep");
  sleep_one_a: assert property (I_POWER_MODE == PWR_SLEEP_ONE &&
    !osc_side |-> !O_LOOP_RUNNING) else $error("loop runs in sleep one");
  sleep_zero_a: assert property (I_POWER_MODE == PWR_SLEEP_ZERO &&
    osc_side |-> O_OSC_ENABLE) else $error("oscillator stopped in use");
  serial_off_a: assert property (O_SERIAL_CLK_EN != serial_idle)
    else $error("serial clock gating wrong");
  low_cur_a: assert property (O_LOW_CURRENT_OK ==
    (I_POWER_MODE == PWR_SLEEP_FOUR && !O_CRYSTAL_ONE_BYPASS))
    else $error("low current permission wrong");
  bypass_wr_a: assert property (I_CE && I_BUS.wr && I_BUS.addr ==
    ADDR_CRYSTAL_CTRL |=> O_CRYSTAL_ONE_BYPASS == $past(I_BUS.wdata[0]))
    else $error("bypass bit not applied");
endmodule : fcs_clock_system_asserts
bind fcs_clock_system fcs_clock_system_asserts u_chk (.I_SYS_CLK, .I_RST_B,
  .I_CE, .I_BUS, .O_RDATA, .I_POWER_MODE, .I_CLOCK_GATE_BIT_TWO,
  .I_IRQ_ACTIVE, .I_SERIAL_OUT_OF_RESET, .I_SERIAL_ASYNC_MODE, .I_SERIAL_BUSY,
  .O_CLK_SEL, .O_OSC_SET, .O_LOOP_RUNNING, .O_OSC_ENABLE, .O_SERIAL_CLK_EN,
  .O_CRYSTAL_ONE_BYPASS, .O_LOW_CURRENT_OK);
`default_nettype wire

// >>> sim/fcs_clock_system_tb.sv
// Self-checking testbench for the clock system.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %0h want %0h", $time, g, e); end end
module fcs_clock_system_tb;
  import fcs_pkg::*;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic clk, rst_b, rf, tk, x1, x2, xo, x1f, x2f, g2, iq, so, sa, sb;
  logic nt, lr, oe, se, byp, lc, nmi, irq;
  logic [15:0] rdata, rv;
  fcs_bus_req_t bus;
  fcs_power_t pm;
  fcs_clk_sel_t sel;
  fcs_osc_set_t os, v;
  int n_mismatch = 0;
  int compares = 0;
  int gap, c;
  fcs_partner PTR (.i_xt1_fit(x1f), .i_xt2_fit(x2f), .o_ref_clk(rf),
    .o_osc_tick(tk), .o_xt1_ok(x1), .o_xt2_ok(x2), .o_osc_ok(xo));
  fcs_clock_system #(.SETTLE_PERIODS(4)) DUT (.I_SYS_CLK(clk),
    .I_RST_B(rst_b), .I_CE(1'b1), .I_BUS(bus), .O_RDATA(rdata),
    .I_REF_CLK(rf), .I_OSC_TICK(tk), .I_CRYSTAL_ONE_OK(x1),
    .I_CRYSTAL_TWO_OK(x2), .I_OSC_OK(xo), .I_POWER_MODE(pm),
    .I_CLOCK_GATE_BIT_TWO(g2), .I_IRQ_ACTIVE(iq), .I_SERIAL_OUT_OF_RESET(so),
    .I_SERIAL_ASYNC_MODE(sa), .I_SERIAL_BUSY(sb), .O_CLK_SEL(sel),
    .O_OSC_SET(os), .O_OSC_USE_NEXT_TAP(nt), .O_LOOP_RUNNING(lr),
    .O_OSC_ENABLE(oe), .O_SERIAL_CLK_EN(se), .O_CRYSTAL_ONE_BYPASS(byp),
    .O_LOW_CURRENT_OK(lc), .O_OSC_FAULT_NMI(nmi), .O_IRQ(irq));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd
  task automatic wait_step(output int g);
    fcs_osc_set_t p;
    p = os;
    g = 0;
    while (os === p && g < 300)
    begin
      cyc(1);
      g++;
    end
  endtask : wait_step
  task automatic count_next(output int n);
    n = 0;
    repeat (32)
    begin
      cyc(1);
      n += nt;
    end
  endtask : count_next
  task automatic t_loop;
    wait_step(gap);
    `CHK(gap <= 70, 1'b1)
    for (int k = 0; k < 40 && os.mod !== 5'h1F; k++)
    begin
      v = os;
      wait_step(gap);
      `CHK(gap >= 46 && gap <= 50, 1'b1)
      `CHK(os, v + 10'h001)
    end
    count_next(c);
    `CHK(c > 0, 1'b1)
    wait_step(gap);
    `CHK(os, 10'h220)
    count_next(c);
    `CHK(c, 0)
    rd(ADDR_IRQ_STATUS, rv);
    `CHK(rv[2:1], 2'b11)
    rd(ADDR_LOOP_STATE, rv);
    `CHK(rv, 16'h0220)
    wr(ADDR_LOOP_TARGET, 16'h0000);
    wait_step(gap);
    wait_step(gap);
    v = os;
    wait_step(gap);
    `CHK(os, v - 10'h001)
  endtask : t_loop
  task automatic t_regs;
    logic [15:0] d;
    rd(ADDR_CLOCK_SELECT, rv);
    `CHK(rv, CLOCK_SELECT_RESET)
    rd(4'h8, rv);
    `CHK(rv, 16'h0000)
    for (int i = 0; i < 6; i++)
    begin
      d = {5'h00, 3'(i), 1'b0, 3'(5 - i), 1'b0, 3'(i + 2)};
      wr(ADDR_CLOCK_SELECT, d);
      cyc(1);
      `CHK(sel, {3'(i), 3'(5 - i), 3'(i + 2)})
      rd(ADDR_CLOCK_SELECT, rv);
      `CHK(rv, d)
    end
  endtask : t_regs
  task automatic t_fault;
    @(posedge clk);
    x1f <= 1'b0;
    cyc(8);
    rd(ADDR_FAULT_STATUS, rv);
    `CHK(rv[3:0], 4'b1001)
    `CHK(nmi, 1'b0)
    x2f <= 1'b0;
    wr(ADDR_CRYSTAL_CTRL, 16'h0002);
    cyc(8);
    `CHK(nmi, 1'b1)
    rd(ADDR_FAULT_STATUS, rv);
    `CHK(rv[3:0], 4'b1011)
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 16'h0001);
    cyc(1);
    `CHK(irq, 1'b1)
    x1f <= 1'b1;
    x2f <= 1'b1;
    cyc(8);
    wr(ADDR_FAULT_STATUS, 16'h0007);
    wr(ADDR_IRQ_STATUS, 16'h0007);
    rd(ADDR_FAULT_STATUS, rv);
    `CHK(rv[3:0], 4'b0000)
    `CHK(nmi, 1'b0)
    `CHK(irq, 1'b0)
  endtask : t_fault
  task automatic run(input fcs_power_t m, input logic g, q, e);
    @(posedge clk);
    pm <= m;
    g2 <= g;
    iq <= q;
    cyc(2);
    `CHK(lr, e)
  endtask : run
  task automatic t_sleep;
    wr(ADDR_CLOCK_SELECT, CLOCK_SELECT_RESET);
    run(PWR_SLEEP_ZERO, 1'b0, 1'b0, 1'b1);
    `CHK(oe, 1'b1)
    wr(ADDR_CLOCK_SELECT, 16'h0300);
    run(PWR_SLEEP_ZERO, 1'b0, 1'b0, 1'b0);
    run(PWR_SLEEP_ZERO, 1'b0, 1'b1, 1'b1);
    run(PWR_SLEEP_ONE, 1'b0, 1'b1, 1'b0);
    run(PWR_SLEEP_THREE, 1'b1, 1'b0, 1'b0);
    run(PWR_SLEEP_THREE, 1'b1, 1'b1, 1'b1);
    so <= 1'b1;
    sa <= 1'b1;
    run(PWR_SLEEP_FOUR, 1'b0, 1'b0, 1'b1);
    `CHK(se, 1'b0)
    `CHK(lc, 1'b1)
    sb <= 1'b1;
    wr(ADDR_CRYSTAL_CTRL, 16'h0001);
    cyc(1);
    `CHK(se, 1'b1)
    `CHK(byp, 1'b1)
    `CHK(lc, 1'b0)
    wr(ADDR_CRYSTAL_CTRL, 16'h0000);
    cyc(1);
    `CHK(byp, 1'b0)
    `CHK(lc, 1'b1)
  endtask : t_sleep
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    {rst_b, g2, iq, so, sa, sb} = '0;
    {x1f, x2f} = 2'b11;
    bus = '0;
    pm = PWR_ACTIVE;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_loop();
    t_regs();
    t_fault();
    t_sleep();
    give_verdict();
  end
endmodule : fcs_clock_system_tb
`default_nettype wire
